// ==== core/spd_params.svh ====
// shared constants of the packed-SIMD prefix decoder
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH
////////////////////////////////////////////////////////////////////////
// prefix bytes
`define SPD_P_LOCK 8'hF0
`define SPD_P_ASZ 8'h67
`define SPD_P_OPSZ 8'h66
`define SPD_P_REP 8'hF3
`define SPD_P_REPNE 8'hF2
`define SPD_P_BH0 8'hE2
`define SPD_P_BH1 8'hE3
`define SPD_P_SEG_ES 8'h26
`define SPD_P_SEG_CS 8'h2E
`define SPD_P_SEG_SS 8'h36
`define SPD_P_SEG_DS 8'h3E
`define SPD_P_SEG_FS 8'h64
`define SPD_P_SEG_GS 8'h65
`define SPD_REX_HI 4'h4
// segment index codes
`define SPD_SEG_ES 3'h0
`define SPD_SEG_CS 3'h1
`define SPD_SEG_SS 3'h2
`define SPD_SEG_DS 3'h3
`define SPD_SEG_FS 3'h4
`define SPD_SEG_GS 3'h5
////////////////////////////////////////////////////////////////////////
// escapes and opcode maps
`define SPD_ESC 8'h0F
`define SPD_ESC_38 8'h38
`define SPD_ESC_3A 8'h3A
`define SPD_MAP_ONE 2'h0
`define SPD_MAP_0F 2'h1
`define SPD_MAP_38 2'h2
`define SPD_MAP_3A 2'h3
// packed-SIMD opcode ranges in the 0F map
`define SPD_SA_LO 8'h10
`define SPD_SA_HI 8'h17
`define SPD_SB_LO 8'h28
`define SPD_SB_HI 8'h2F
`define SPD_SC_LO 8'h50
`define SPD_SC_HI 8'h7F
`define SPD_SD_LO 8'hC2
`define SPD_SD_HI 8'hC6
`define SPD_SE_LO 8'hD0
`define SPD_SE_HI 8'hFF
`define SPD_PK_LO 8'h60
`define SPD_IMM_LO 8'h70
`define SPD_IMM_HI 8'h73
// special opcodes and operand forms
`define SPD_OP_FENCE 8'hAE
`define SPD_OP_PREF 8'h18
`define SPD_OP_NTI 8'hC3
`define SPD_OP_GRP7 8'h01
`define SPD_FORM_WATCH 8'hC8
`define SPD_FORM_WAIT 8'hC9
`define SPD_OP_X87A 8'hDB
`define SPD_OP_X87B 8'hDD
`define SPD_OP_X87C 8'hDF
`define SPD_OP_GPR_LO 8'hF0
`define SPD_OP_GPR_HI 8'hF1
`define SPD_R_STORE_ORDER_FENCE 3'h7
`define SPD_R_FULL_MEMORY_FENCE 3'h6
`define SPD_R_SAVE 3'h0
`define SPD_R_RSTR 3'h1
`define SPD_R_TRUNC 3'h1
////////////////////////////////////////////////////////////////////////
// operand form fields
`define SPD_MOD_REG 2'h3
`define SPD_MOD_D8 2'h1
`define SPD_MOD_D16 2'h2
`define SPD_MOD_NONE 2'h0
`define SPD_RM_SIB 3'h4
`define SPD_RM_ABS 3'h5
`define SPD_RM_ABS16 3'h6
`define SPD_DISP_0 3'h0
`define SPD_DISP_1 3'h1
`define SPD_DISP_2 3'h2
`define SPD_DISP_4 3'h4
// saved state groups: vector, control, x87, legacy packed
`define SPD_STATE_ALL 4'hF
`define SPD_STATE_NONE 4'h0
`endif

// ==== core/spd_pkg.sv ====
// types shared by the packed-SIMD prefix decoder
package spd_pkg;
  // collection states
  typedef enum {
    SPD_S_PFX,
    SPD_S_ESC,
    SPD_S_MAP,
    SPD_S_FORM,
    SPD_S_SIB,
    SPD_S_DISP,
    SPD_S_IMM
  } spd_state_t;
  // decoded instruction class
  typedef enum logic [3:0] {
    SPD_C_NONE,
    SPD_C_SIMD,
    SPD_C_STORE_ORDER_FENCE,
    SPD_C_FULL_MEMORY_FENCE,
    SPD_C_CACHE_PREFETCH_HINT,
    SPD_C_NONTEMPORAL_INT_STORE,
    SPD_C_TRUNCATING_INT_STORE_POP,
    SPD_C_ADDRESS_WATCH,
    SPD_C_WATCH_WAIT,
    SPD_C_WHOLE_STATE_SAVE,
    SPD_C_WHOLE_STATE_RESTORE,
    SPD_C_GPR_OP
  } spd_class_t;
  // mandatory prefix
  typedef enum logic [1:0] {
    SPD_MP_NONE,
    SPD_MP_OPSZ,
    SPD_MP_REP,
    SPD_MP_REPNE
  } spd_mand_t;
  // effective address width
  typedef enum logic [1:0] {SPD_EA16, SPD_EA32, SPD_EA64} spd_eaw_t;
endpackage

// ==== core/spd_operand_form.sv ====
// shape of a memory operand from operand form and index bytes
`timescale 1ns/1ps
`include "spd_params.svh"
module spd_operand_form (
  // operand form and index bytes
  input logic [7:0] formByte,
  input logic [7:0] sibByte,
  // address width
  input spd_pkg::spd_eaw_t eaWidth,
  // operand shape
  output logic isMem,
  output logic needSib,
  output logic ripRel,
  output logic [2:0] dispLen
);
  wire [1:0] md = formByte[7:6];
  wire [2:0] rm = formByte[2:0];
  wire is16 = (eaWidth == spd_pkg::SPD_EA16);
  wire noBase16;
  wire noBase;
  // field decode
  assign isMem = (md != `SPD_MOD_REG);
  assign needSib = isMem && !is16 && (rm == `SPD_RM_SIB);
  assign noBase16 = is16 && (md == `SPD_MOD_NONE) && (rm == `SPD_RM_ABS16);
  assign noBase = !is16 && (md == `SPD_MOD_NONE) &&
    ((rm == `SPD_RM_ABS) || (needSib && sibByte[2:0] == `SPD_RM_ABS));
  assign ripRel = (eaWidth == spd_pkg::SPD_EA64) &&
    (md == `SPD_MOD_NONE) && (rm == `SPD_RM_ABS);
  // displacement length in bytes
  assign dispLen = (md == `SPD_MOD_D8) ? `SPD_DISP_1 :
    (md == `SPD_MOD_D16) ? (is16 ? `SPD_DISP_2 : `SPD_DISP_4) :
    noBase16 ? `SPD_DISP_2 : noBase ? `SPD_DISP_4 : `SPD_DISP_0;
endmodule

// ==== core/spd_decoder.sv ====
// packed-SIMD prefix, escape and operand form decoder
`timescale 1ns/1ps
`include "spd_params.svh"
module spd_decoder (
  // clock and reset
  input logic mclk,
  input logic reset,
  // instruction byte stream
  input logic byteValid,
  input logic [7:0] byteIn,
  // processor mode
  input logic mode64,
  input logic compatMode,
  input logic codeSeg32,
  // store ordering
  input logic olderStoresPending,
  output logic storeHold_r,
  // decode result
  output logic decValid_r,
  output logic udFault_r,
  output spd_pkg::spd_class_t insnClass_r,
  output spd_pkg::spd_mand_t mandPrefix_r,
  output logic [7:0] opcode_r,
  output logic [1:0] opMap_r,
  output logic isSimd_r,
  output logic memOperand_r,
  output logic ripRel_r,
  output spd_pkg::spd_eaw_t eaWidth_r,
  output logic segValid_r,
  output logic [2:0] segIdx_r,
  output logic [3:0] vecRegIdx_r,
  output logic [3:0] vecRmIdx_r,
  output logic gprWide_r,
  output logic reservedPfx_r,
  output logic regWriteEn_r,
  output logic memWriteEn_r,
  output logic cacheAlloc_r,
  output logic roundTrunc_r,
  output logic fpCtrlSimd_r,
  output logic usesLegacyPk_r,
  output logic [3:0] stateMask_r
);
  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic inRange(input logic [7:0] o,
    input logic [7:0] lo, input logic [7:0] hi);
    inRange = (o >= lo) && (o <= hi);
  endfunction

  function automatic logic simdOp(input logic [7:0] o,
    input logic [1:0] m);
    simdOp = (m == `SPD_MAP_38) || (m == `SPD_MAP_3A) ||
      ((m == `SPD_MAP_0F) && (inRange(o, `SPD_SA_LO, `SPD_SA_HI) ||
      inRange(o, `SPD_SB_LO, `SPD_SB_HI) ||
      inRange(o, `SPD_SC_LO, `SPD_SC_HI) ||
      inRange(o, `SPD_SD_LO, `SPD_SD_HI) ||
      inRange(o, `SPD_SE_LO, `SPD_SE_HI) ||
      (o == `SPD_OP_PREF) || (o == `SPD_OP_FENCE)));
  endfunction

  function automatic logic immOp(input logic [7:0] o,
    input logic [1:0] m);
    immOp = (m == `SPD_MAP_3A) || ((m == `SPD_MAP_0F) &&
      (inRange(o, `SPD_IMM_LO, `SPD_IMM_HI) ||
      (inRange(o, `SPD_SD_LO, `SPD_SD_HI) && o != `SPD_OP_NTI)));
  endfunction

  function automatic logic x87Op(input logic [7:0] o);
    x87Op = (o == `SPD_OP_X87A) || (o == `SPD_OP_X87B) ||
      (o == `SPD_OP_X87C);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // collection state
  spd_pkg::spd_state_t state_r;
  spd_pkg::spd_state_t stateNxt;
  spd_pkg::spd_mand_t mp_r;
  logic [2:0] cnt_r;
  logic [2:0] cntNxt;
  logic finish;
  logic done_r;
  logic fresh_r;
  logic lock_r;
  logic asz_r;
  logic bh_r;
  logic segSeen_r;
  logic [2:0] segCode_r;
  logic mpMulti_r;
  logic rexV_r;
  logic [3:0] rex_r;
  logic [1:0] map_r;
  logic [7:0] opc_r;
  logic [7:0] form_r;
  logic [7:0] sib_r;
  logic formSeen_r;
  spd_pkg::spd_class_t clsD;

  // compatibility mode decodes exactly as protected mode
  wire eff64 = mode64 && !compatMode;
  wire keep = !fresh_r;
  wire inPfx = byteValid && (state_r == spd_pkg::SPD_S_PFX);

  // prefix byte recognition
  wire pLock = (byteIn == `SPD_P_LOCK);
  wire pAsz = (byteIn == `SPD_P_ASZ);
  wire pOpsz = (byteIn == `SPD_P_OPSZ);
  wire pRep = (byteIn == `SPD_P_REP);
  wire pRepne = (byteIn == `SPD_P_REPNE);
  wire pMand = pOpsz || pRep || pRepne;
  wire pBh = (byteIn == `SPD_P_BH0) || (byteIn == `SPD_P_BH1);
  wire pSegEs = (byteIn == `SPD_P_SEG_ES);
  wire pSegCs = (byteIn == `SPD_P_SEG_CS);
  wire pSegSs = (byteIn == `SPD_P_SEG_SS);
  wire pSegDs = (byteIn == `SPD_P_SEG_DS);
  wire pSegFs = (byteIn == `SPD_P_SEG_FS);
  wire pSegGs = (byteIn == `SPD_P_SEG_GS);
  wire pSeg = pSegEs || pSegCs || pSegSs || pSegDs || pSegFs || pSegGs;
  wire pRex = eff64 && (byteIn[7:4] == `SPD_REX_HI);
  wire pLegacy = pLock || pAsz || pMand || pBh || pSeg;
  wire pAny = pLegacy || pRex;
  wire [2:0] segOf = pSegCs ? `SPD_SEG_CS : pSegSs ? `SPD_SEG_SS :
    pSegDs ? `SPD_SEG_DS : pSegFs ? `SPD_SEG_FS :
    pSegGs ? `SPD_SEG_GS : `SPD_SEG_ES;
  wire [1:0] mpOf = pOpsz ? spd_pkg::SPD_MP_OPSZ :
    pRep ? spd_pkg::SPD_MP_REP : spd_pkg::SPD_MP_REPNE;

  // address width follows mode and address-size prefix
  wire [1:0] eawNow = eff64 ? (asz_r ? spd_pkg::SPD_EA32 :
    spd_pkg::SPD_EA64) : ((codeSeg32 ^ asz_r) ? spd_pkg::SPD_EA32 :
    spd_pkg::SPD_EA16);

  // operand form shape, live byte while it arrives
  wire [7:0] formIn = (state_r == spd_pkg::SPD_S_FORM) ? byteIn : form_r;
  wire [7:0] sibIn = (state_r == spd_pkg::SPD_S_SIB) ? byteIn : sib_r;
  wire fIsMem;
  wire fNeedSib;
  wire fRip;
  wire [2:0] fDisp;
  wire immNeed = immOp(opc_r, map_r);

  spd_operand_form uForm (
    .formByte(formIn),
    .sibByte(sibIn),
    .eaWidth(spd_pkg::spd_eaw_t'(eawNow)),
    .isMem(fIsMem),
    .needSib(fNeedSib),
    .ripRel(fRip),
    .dispLen(fDisp)
  );

  ////////////////////////////////////////////////////////////////////
  // byte sequencing: prefixes, escape, map, form, index, disp, imm
  always_comb begin
    stateNxt = state_r;
    cntNxt = cnt_r;
    finish = 1'h0;
    if (byteValid) begin
      case (state_r)
        spd_pkg::SPD_S_PFX: begin
          if (!pAny) begin
            if (byteIn == `SPD_ESC) stateNxt = spd_pkg::SPD_S_ESC;
            else if (x87Op(byteIn)) stateNxt = spd_pkg::SPD_S_FORM;
            else finish = 1'h1;
          end
        end
        spd_pkg::SPD_S_ESC: begin
          if (byteIn == `SPD_ESC_38 || byteIn == `SPD_ESC_3A) begin
            stateNxt = spd_pkg::SPD_S_MAP;
          end else if (simdOp(byteIn, `SPD_MAP_0F) ||
            byteIn == `SPD_OP_GRP7) begin
            stateNxt = spd_pkg::SPD_S_FORM;
          end else finish = 1'h1;
        end
        spd_pkg::SPD_S_MAP: stateNxt = spd_pkg::SPD_S_FORM;
        spd_pkg::SPD_S_FORM: begin
          if (fNeedSib) stateNxt = spd_pkg::SPD_S_SIB;
          else if (fDisp != `SPD_DISP_0) begin
            stateNxt = spd_pkg::SPD_S_DISP;
            cntNxt = fDisp;
          end else if (immNeed) stateNxt = spd_pkg::SPD_S_IMM;
          else finish = 1'h1;
        end
        spd_pkg::SPD_S_SIB: begin
          if (fDisp != `SPD_DISP_0) begin
            stateNxt = spd_pkg::SPD_S_DISP;
            cntNxt = fDisp;
          end else if (immNeed) stateNxt = spd_pkg::SPD_S_IMM;
          else finish = 1'h1;
        end
        spd_pkg::SPD_S_DISP: begin
          cntNxt = cnt_r - 3'h1;
          if (cnt_r == `SPD_DISP_1) begin
            if (immNeed) stateNxt = spd_pkg::SPD_S_IMM;
            else finish = 1'h1;
          end
        end
        spd_pkg::SPD_S_IMM: finish = 1'h1;
        default: stateNxt = spd_pkg::SPD_S_PFX;
      endcase
    end
    if (finish) stateNxt = spd_pkg::SPD_S_PFX;
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= spd_pkg::SPD_S_PFX;
      cnt_r <= `SPD_DISP_0;
      done_r <= 1'h0;
      fresh_r <= 1'h1;
    end else begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
      done_r <= finish;
      fresh_r <= finish || (fresh_r && !inPfx);
    end
  end

  // prefix accumulation, cleared by the first byte of a new instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      lock_r <= 1'h0;
      asz_r <= 1'h0;
      bh_r <= 1'h0;
      segSeen_r <= 1'h0;
      segCode_r <= `SPD_SEG_ES;
      mp_r <= spd_pkg::SPD_MP_NONE;
      mpMulti_r <= 1'h0;
      rexV_r <= 1'h0;
      rex_r <= 4'h0;
    end else if (inPfx) begin
      lock_r <= (lock_r && keep) || pLock;
      asz_r <= (asz_r && keep) || pAsz;
      bh_r <= (bh_r && keep) || pBh;
      segSeen_r <= (segSeen_r && keep) || pSeg;
      if (pSeg) segCode_r <= segOf;
      if (pMand) mp_r <= spd_pkg::spd_mand_t'(mpOf);
      else if (fresh_r) mp_r <= spd_pkg::SPD_MP_NONE;
      mpMulti_r <= (mpMulti_r && keep) ||
        (pMand && keep && mp_r != spd_pkg::SPD_MP_NONE);
      // an extension prefix counts only right before the opcode
      rexV_r <= pRex || (rexV_r && keep && !pLegacy);
      if (pRex) rex_r <= byteIn[3:0];
    end
  end

  // opcode, map and operand bytes
  always_ff @(posedge mclk) begin
    if (reset) begin
      map_r <= `SPD_MAP_ONE;
      opc_r <= 8'h00;
      form_r <= 8'h00;
      sib_r <= 8'h00;
      formSeen_r <= 1'h0;
    end else if (byteValid) begin
      if (inPfx && !pAny) begin
        map_r <= `SPD_MAP_ONE;
        opc_r <= byteIn;
        formSeen_r <= 1'h0;
      end
      if (state_r == spd_pkg::SPD_S_ESC) begin
        map_r <= (byteIn == `SPD_ESC_38) ? `SPD_MAP_38 :
          (byteIn == `SPD_ESC_3A) ? `SPD_MAP_3A : `SPD_MAP_0F;
        opc_r <= byteIn;
      end
      if (state_r == spd_pkg::SPD_S_MAP) opc_r <= byteIn;
      if (state_r == spd_pkg::SPD_S_FORM) begin
        form_r <= byteIn;
        formSeen_r <= 1'h1;
      end
      if (state_r == spd_pkg::SPD_S_SIB) sib_r <= byteIn;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // instruction decode from the collected bytes
  wire [2:0] fReg = form_r[5:3];
  wire memD = formSeen_r && fIsMem;
  wire map0F = (map_r == `SPD_MAP_0F);

  always_comb begin
    clsD = spd_pkg::SPD_C_NONE;
    if (map0F && opc_r == `SPD_OP_FENCE) begin
      if (!memD && fReg == `SPD_R_STORE_ORDER_FENCE)
        clsD = spd_pkg::SPD_C_STORE_ORDER_FENCE;
      else if (!memD && fReg == `SPD_R_FULL_MEMORY_FENCE)
        clsD = spd_pkg::SPD_C_FULL_MEMORY_FENCE;
      else if (memD && fReg == `SPD_R_SAVE)
        clsD = spd_pkg::SPD_C_WHOLE_STATE_SAVE;
      else if (memD && fReg == `SPD_R_RSTR)
        clsD = spd_pkg::SPD_C_WHOLE_STATE_RESTORE;
      else clsD = spd_pkg::SPD_C_SIMD;
    end else if (map0F && opc_r == `SPD_OP_PREF) begin
      clsD = spd_pkg::SPD_C_CACHE_PREFETCH_HINT;
    end else if (map0F && opc_r == `SPD_OP_NTI) begin
      clsD = spd_pkg::SPD_C_NONTEMPORAL_INT_STORE;
    end else if (map0F && opc_r == `SPD_OP_GRP7) begin
      if (form_r == `SPD_FORM_WATCH) clsD = spd_pkg::SPD_C_ADDRESS_WATCH;
      else if (form_r == `SPD_FORM_WAIT) clsD = spd_pkg::SPD_C_WATCH_WAIT;
    end else if (map_r == `SPD_MAP_38 &&
      inRange(opc_r, `SPD_OP_GPR_LO, `SPD_OP_GPR_HI)) begin
      clsD = spd_pkg::SPD_C_GPR_OP;
    end else if (map_r == `SPD_MAP_ONE && x87Op(opc_r) && memD &&
      fReg == `SPD_R_TRUNC) begin
      clsD = spd_pkg::SPD_C_TRUNCATING_INT_STORE_POP;
    end else if (simdOp(opc_r, map_r)) begin
      clsD = spd_pkg::SPD_C_SIMD;
    end
  end

  // class groups
  wire cSimd = (clsD == spd_pkg::SPD_C_SIMD);
  wire cNt = (clsD == spd_pkg::SPD_C_NONTEMPORAL_INT_STORE);
  wire cGpr = (clsD == spd_pkg::SPD_C_GPR_OP);
  wire cSave = (clsD == spd_pkg::SPD_C_WHOLE_STATE_SAVE);
  wire cRstr = (clsD == spd_pkg::SPD_C_WHOLE_STATE_RESTORE);
  wire cTrunc = (clsD == spd_pkg::SPD_C_TRUNCATING_INT_STORE_POP);
  wire cFence = (clsD == spd_pkg::SPD_C_STORE_ORDER_FENCE) ||
    (clsD == spd_pkg::SPD_C_FULL_MEMORY_FENCE);
  wire famD = (clsD != spd_pkg::SPD_C_NONE);

  // fault and effects; prefetch, watch, wait and fences write nothing
  wire udD = lock_r && famD;
  wire memWrD = !udD && (cSave || cNt || cTrunc);
  wire regWrD = !udD && (cSimd || cRstr || cGpr);
  wire legacyD = cSimd && map0F && mp_r == spd_pkg::SPD_MP_NONE &&
    (inRange(opc_r, `SPD_PK_LO, `SPD_SC_HI) ||
    inRange(opc_r, `SPD_SE_LO, `SPD_SE_HI));
  wire wideD = rexV_r && rex_r[3] && (cNt || cGpr);
  wire resvD = (cSimd && (bh_r || mpMulti_r)) ||
    (famD && (asz_r || segSeen_r) && !memD);
  wire [1:0] mandD = (map_r == `SPD_MAP_ONE) ?
    spd_pkg::SPD_MP_NONE : mp_r;

  // decode outputs, loaded once per instruction
  always_ff @(posedge mclk) begin
    if (reset) begin
      decValid_r <= 1'h0;
      udFault_r <= 1'h0;
      insnClass_r <= spd_pkg::SPD_C_NONE;
      mandPrefix_r <= spd_pkg::SPD_MP_NONE;
      opcode_r <= 8'h00;
      opMap_r <= `SPD_MAP_ONE;
      isSimd_r <= 1'h0;
      memOperand_r <= 1'h0;
      ripRel_r <= 1'h0;
      eaWidth_r <= spd_pkg::SPD_EA16;
      segValid_r <= 1'h0;
      segIdx_r <= `SPD_SEG_ES;
      vecRegIdx_r <= 4'h0;
      vecRmIdx_r <= 4'h0;
      gprWide_r <= 1'h0;
      reservedPfx_r <= 1'h0;
      regWriteEn_r <= 1'h0;
      memWriteEn_r <= 1'h0;
      cacheAlloc_r <= 1'h0;
      roundTrunc_r <= 1'h0;
      fpCtrlSimd_r <= 1'h0;
      usesLegacyPk_r <= 1'h0;
      stateMask_r <= `SPD_STATE_NONE;
    end else begin
      decValid_r <= done_r;
      if (done_r) begin
        udFault_r <= udD;
        insnClass_r <= clsD;
        mandPrefix_r <= spd_pkg::spd_mand_t'(mandD);
        opcode_r <= opc_r;
        opMap_r <= map_r;
        isSimd_r <= famD;
        memOperand_r <= memD;
        ripRel_r <= memD && fRip;
        eaWidth_r <= spd_pkg::spd_eaw_t'(eawNow);
        segValid_r <= segSeen_r && memD;
        segIdx_r <= segCode_r;
        vecRegIdx_r <= {rexV_r && rex_r[2], fReg};
        vecRmIdx_r <= {rexV_r && rex_r[0] && !memD, form_r[2:0]};
        gprWide_r <= wideD;
        reservedPfx_r <= resvD;
        regWriteEn_r <= regWrD;
        memWriteEn_r <= memWrD;
        cacheAlloc_r <= memWrD && !cNt;
        roundTrunc_r <= cTrunc;
        fpCtrlSimd_r <= cSimd && !legacyD;
        usesLegacyPk_r <= legacyD;
        stateMask_r <= (cSave || cRstr) ? `SPD_STATE_ALL :
          `SPD_STATE_NONE;
      end
    end
  end

  // younger stores wait until all older stores are visible
  always_ff @(posedge mclk) begin
    if (reset) storeHold_r <= 1'h0;
    else storeHold_r <= (done_r && !udD && cFence) ||
      (storeHold_r && olderStoresPending);
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence sLockedFam;
    done_r && lock_r && famD;
  endsequence
  sequence sFenceOut;
    decValid_r && !udFault_r &&
    (insnClass_r == spd_pkg::SPD_C_STORE_ORDER_FENCE ||
    insnClass_r == spd_pkg::SPD_C_FULL_MEMORY_FENCE);
  endsequence

  a_lock_fault: assert property (
    sLockedFam |=> decValid_r && udFault_r)
    else $error("locked SIMD instruction did not fault");
  a_fault_quiet: assert property (
    decValid_r && udFault_r |-> !regWriteEn_r && !memWriteEn_r)
    else $error("faulting instruction enables a write");
  a_fence_hold: assert property (
    sFenceOut |-> storeHold_r ##1 (storeHold_r || !$past(olderStoresPending)))
    else $error("fence released stores too early");
  a_hold_release: assert property (
    storeHold_r && !olderStoresPending && !done_r |=> !storeHold_r)
    else $error("store hold stuck after drain");
  a_prefetch_quiet: assert property (
    decValid_r && insnClass_r == spd_pkg::SPD_C_CACHE_PREFETCH_HINT
    |-> !regWriteEn_r && !memWriteEn_r)
    else $error("prefetch hint writes state");
  a_nt_noalloc: assert property (
    decValid_r && !udFault_r &&
    insnClass_r == spd_pkg::SPD_C_NONTEMPORAL_INT_STORE
    |-> memWriteEn_r && !cacheAlloc_r)
    else $error("non-temporal store allocates");
  a_trunc_round: assert property (
    decValid_r |-> roundTrunc_r ==
    (insnClass_r == spd_pkg::SPD_C_TRUNCATING_INT_STORE_POP))
    else $error("truncation flag wrong");
  a_watch_keep: assert property (
    decValid_r && (insnClass_r == spd_pkg::SPD_C_ADDRESS_WATCH ||
    insnClass_r == spd_pkg::SPD_C_WATCH_WAIT) |-> !regWriteEn_r)
    else $error("watch or wait writes a register");
  a_save_mask: assert property (
    decValid_r && insnClass_r == spd_pkg::SPD_C_WHOLE_STATE_SAVE
    |-> stateMask_r == `SPD_STATE_ALL)
    else $error("state save misses a group");
  a_ext_regs: assert property (
    decValid_r && vecRegIdx_r[3] |-> $past(eff64))
    else $error("upper vector register outside 64-bit mode");
  a_wide_gpr: assert property (
    decValid_r && gprWide_r |-> $past(cNt || cGpr))
    else $error("wide bit applied where it has no meaning");
endmodule

// ==== bench/spd_decoder_bench.sv ====
// self-checking bench of the packed-SIMD prefix decoder
`timescale 1ns/1ps
module spd_decoder_bench;
  // one table row: bytes, count, mode, expected decode fields
  typedef struct {
    logic [31:0] b;
    int n;
    logic m64, ud;
    logic [3:0] c;
    logic rw, mw, mem;
    logic [1:0] ea;
    logic sg;
    logic [1:0] mp;
    logic rs;
    logic [3:0] vr;
    logic wd;
  } spd_row_t;
  logic mclk = 1'b0, reset = 1'b1, byteValid = 1'b0, mode64 = 1'b0;
  logic compatMode = 1'b0, codeSeg32 = 1'b1, olderStoresPending = 1'b0;
  logic [7:0] byteIn = 8'h00;
  logic storeHold_r, decValid_r, udFault_r, memOperand_r, segValid_r;
  logic gprWide_r, reservedPfx_r, regWriteEn_r, memWriteEn_r, cacheAlloc_r;
  logic roundTrunc_r, fpCtrlSimd_r, usesLegacyPk_r;
  logic [3:0] insnClass_r, vecRegIdx_r, stateMask_r;
  logic [1:0] mandPrefix_r, eaWidth_r;
  logic [2:0] segIdx_r;
  logic [7:0] opcode_r;
  logic [1:0] opMap_r;
  logic isSimd_r, ripRel_r;
  logic [3:0] vecRmIdx_r;
  int failures = 0, checkCount = 0, cycles = 0;
  spd_row_t r;
  spd_row_t rows [15] = '{
    '{32'hF00F58C1, 4, 0, 1, 1, 0, 0, 0, 1, 0, 0, 0, 0, 0},
    '{32'h000F58C1, 3, 0, 0, 1, 1, 0, 0, 1, 0, 0, 0, 0, 0},
    '{32'h000FAEF8, 3, 0, 0, 2, 0, 0, 0, 1, 0, 0, 0, 7, 0},
    '{32'h000FAEF0, 3, 0, 0, 3, 0, 0, 0, 1, 0, 0, 0, 6, 0},
    '{32'h000F1808, 3, 0, 0, 4, 0, 0, 1, 1, 0, 0, 0, 1, 0},
    '{32'h000FC300, 3, 0, 0, 5, 0, 1, 1, 1, 0, 0, 0, 0, 0},
    '{32'h670F5800, 4, 0, 0, 1, 1, 0, 1, 0, 0, 0, 0, 0, 0},
    '{32'h2E0F5800, 4, 0, 0, 1, 1, 0, 1, 1, 1, 0, 0, 0, 0},
    '{32'h660F58C1, 4, 0, 0, 1, 1, 0, 0, 1, 0, 1, 0, 0, 0},
    '{32'h2E0F58C1, 4, 0, 0, 1, 1, 0, 0, 1, 0, 0, 1, 0, 0},
    '{32'hE20F58C1, 4, 0, 0, 1, 1, 0, 0, 1, 0, 0, 1, 0, 0},
    '{32'h440F58C1, 4, 1, 0, 1, 1, 0, 0, 2, 0, 0, 0, 8, 0},
    '{32'h480FC300, 4, 1, 0, 5, 0, 1, 1, 2, 0, 0, 0, 0, 1},
    '{32'h480F58C1, 4, 1, 0, 1, 1, 0, 0, 2, 0, 0, 0, 0, 0},
    '{32'h0F38F0C1, 4, 0, 0, 11, 1, 0, 0, 1, 0, 0, 0, 0, 0}};

  spd_decoder spd_decoder_i (.mclk, .reset, .byteValid, .byteIn, .mode64,
    .compatMode, .codeSeg32, .olderStoresPending, .storeHold_r, .decValid_r,
    .udFault_r, .insnClass_r, .mandPrefix_r, .opcode_r, .opMap_r,
    .isSimd_r, .memOperand_r, .ripRel_r, .eaWidth_r, .segValid_r,
    .segIdx_r, .vecRegIdx_r, .vecRmIdx_r, .gprWide_r, .reservedPfx_r,
    .regWriteEn_r, .memWriteEn_r, .cacheAlloc_r, .roundTrunc_r,
    .fpCtrlSimd_r, .usesLegacyPk_r, .stateMask_r);

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  // compare and count
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    checkCount++;
    if (s !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  // send n bytes at falling edges; decode pulse two edges after the last
  task automatic run(logic [63:0] b, int n);
    for (int i = n - 1; i >= 0; i--) begin
      byteValid = 1'b1;
      byteIn = b[8*i +: 8];
      @(negedge mclk);
    end
    byteValid = 1'b0;
    @(negedge mclk);
    chk("decValid", decValid_r, 1'b1);
  endtask

  task automatic trow(spd_row_t t);
    mode64 = t.m64;
    run(t.b, t.n);
    chk("row", {udFault_r, insnClass_r, regWriteEn_r, memWriteEn_r,
      memOperand_r, eaWidth_r, segValid_r, mandPrefix_r, reservedPfx_r,
      vecRegIdx_r, gprWide_r}, {t.ud, t.c, t.rw, t.mw, t.mem, t.ea, t.sg,
      t.mp, t.rs, t.vr, t.wd});
  endtask

  task automatic complete_run();
    if (failures == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    chk("reset", {decValid_r, udFault_r, insnClass_r, eaWidth_r},
      8'h00);
    @(negedge mclk);
    foreach (rows[i]) trow(rows[i]);
    r = rows[1];
    r.m64 = 1'b1;
    compatMode = 1'b1;
    trow(r);
    compatMode = 1'b0;
    mode64 = 1'b0;
    // register form: no segment applied, code keeps the last override
    chk("segIdx", {segValid_r, segIdx_r}, 4'h1);
    run(32'h2E0F5800, 4);
    chk("segIdx", {segValid_r, segIdx_r}, 4'h9);
    run(32'h000FAE00, 3);
    chk("save", {insnClass_r, stateMask_r}, 8'h9F);
    run(32'h000FAE08, 3);
    chk("restore", {insnClass_r, stateMask_r}, 8'hAF);
    run(32'hF00FAE00, 4);
    chk("lock", {udFault_r, memWriteEn_r, regWriteEn_r}, 3'h4);
    run(32'h0000DB08, 2);
    chk("trunc", {insnClass_r, roundTrunc_r, fpCtrlSimd_r}, 6'h1A);
    run(32'h000F01C8, 3);
    chk("watch", {insnClass_r, regWriteEn_r}, 5'h0E);
    run(32'h000F01C9, 3);
    chk("wait", {insnClass_r, regWriteEn_r}, 5'h10);
    run(32'h000FC300, 3);
    chk("cacheAlloc", cacheAlloc_r, 1'b0);
    run(32'h000F58C1, 3);
    chk("simd", {fpCtrlSimd_r, usesLegacyPk_r}, 2'h2);
    run(32'h000F60C1, 3);
    chk("legacy", usesLegacyPk_r, 1'b1);
    run(32'h660F60C1, 4);
    chk("legacy", usesLegacyPk_r, 1'b0);
    run(32'h0F3800C1, 4);
    chk("legacy", usesLegacyPk_r, 1'b0);
    // long forms: imm after 0F3A, index plus disp8, 16/32-bit switch
    run(64'h660F3A0FC108, 6);
    chk("map", {mandPrefix_r, opMap_r, opcode_r, isSimd_r},
      13'h0E1F);
    run(64'h0F58442410, 5);
    chk("sib", {memOperand_r, opcode_r}, 9'h158);
    codeSeg32 = 1'b0;
    run(32'h670F5800, 4);
    chk("ea", eaWidth_r, 2'h1);
    codeSeg32 = 1'b1;
    // 64-bit forms: relative address, extended rm register, wide register op
    mode64 = 1'b1;
    run(64'h000F580578563412, 7);
    chk("rip", {ripRel_r, memOperand_r, eaWidth_r}, 4'hE);
    run(32'h410F58C1, 4);
    chk("rm", {vecRegIdx_r, vecRmIdx_r}, 8'h09);
    run(64'h480F38F0C1, 5);
    chk("gpr", {insnClass_r, gprWide_r}, 5'h17);
    mode64 = 1'b0;
    // fence holds younger stores while older ones are pending
    olderStoresPending = 1'b1;
    run(32'h000FAEF8, 3);
    repeat (3) @(negedge mclk);
    chk("hold", storeHold_r, 1'b1);
    olderStoresPending = 1'b0;
    repeat (2) @(negedge mclk);
    chk("hold", storeHold_r, 1'b0);
    // reset in mid-run clears a pending hold
    olderStoresPending = 1'b1;
    run(32'h000FAEF0, 3);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    chk("reset", {storeHold_r, decValid_r, insnClass_r}, 6'h00);
    olderStoresPending = 1'b0;
    @(negedge mclk);
    trow(rows[0]);
    complete_run();
  end
endmodule
